// ===== verilog/rsc_defines.vh
/*
 * rsc_defines.vh: register offsets, field positions, reset values and codes
 * for the receive signal-processing configuration bank.
 * Assumes: included by bare name; definitions only.
 */
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ****************************************************************
// register map (printed offsets are indices, byte address = 4*index)
// ****************************************************************
`define RSC_IDX_CM_CONFIG      8'h1B
`define RSC_IDX_RM_CONFIG      8'h1C
`define RSC_IDX_W              8

// ****************************************************************
// card-mode configuration fields
// ****************************************************************
`define RSC_CM_FRAMING_HI      30
`define RSC_CM_FRAMING_LO      29
`define RSC_CM_TAPSEL_HI       28
`define RSC_CM_TAPSEL_LO       26
`define RSC_CM_EDGE_TH_HI      25
`define RSC_CM_EDGE_TH_LO      13
`define RSC_CM_BIT_TH_HI       12
`define RSC_CM_BIT_TH_LO       0
`define RSC_CM_WMASK           32'h7FFFFFFF

// ****************************************************************
// reader-mode configuration fields
// ****************************************************************
`define RSC_RM_CHSEL_HI        23
`define RSC_RM_CHSEL_LO        21
`define RSC_RM_WMASK           32'h00FFFFFF

// ****************************************************************
// reset values
// ****************************************************************
`define RSC_CM_RESET           32'h00000000
`define RSC_RM_RESET           32'h00000000
`define RSC_RDATA_UNMAPPED     32'h00000000

// ****************************************************************
// framing codes
// ****************************************************************
`define RSC_FRAME_14443A       2'h0
`define RSC_FRAME_18092        2'h1
`define RSC_SYNC_BYTE_18092    8'hF0

// ****************************************************************
// channel-select codes
// ****************************************************************
`define RSC_CH_BOTH            3'h0
`define RSC_CH_I_ONLY          3'h1
`define RSC_CH_Q_ONLY          3'h2
`define RSC_CH_STRONGEST       3'h4
`define RSC_CH_FIRST           3'h5

// ****************************************************************
// tap counts
// ****************************************************************
`define RSC_TAPS_0             6'h04
`define RSC_TAPS_1             6'h06
`define RSC_TAPS_2             6'h08
`define RSC_TAPS_3             6'h08
`define RSC_TAPS_4             6'h10
`define RSC_TAPS_5             6'h12
`define RSC_TAPS_6             6'h18
`define RSC_TAPS_7             6'h20

`endif

// ===== verilog/rsc_channel_decode.v
/*
 * rsc_channel_decode.v: turns the phase channel-select code into
 * per-channel enables and selection-strategy flags.
 * Assumes: pure combinational use from the register bank.
 */
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_channel_decode (
   // code in
   input  wire [2:0] chanSel,
   // decoded
   output reg        useI,
   output reg        useQ,
   output reg        pickStrongest,
   output reg        pickFirst,
   output reg        chanReserved
);

   always @* begin
      useI          = 1'b0;
      useQ          = 1'b0;
      pickStrongest = 1'b0;
      pickFirst     = 1'b0;
      chanReserved  = 1'b0;
      case (chanSel)
         // R06: both, I or Q
         `RSC_CH_BOTH: begin
            useI = 1'b1;
            useQ = 1'b1;
         end
         `RSC_CH_I_ONLY: begin
            useI = 1'b1;
         end
         `RSC_CH_Q_ONLY: begin
            useQ = 1'b1;
         end
         // R07: strongest or earliest channel
         `RSC_CH_STRONGEST: begin
            useI          = 1'b1;
            useQ          = 1'b1;
            pickStrongest = 1'b1;
         end
         `RSC_CH_FIRST: begin
            useI      = 1'b1;
            useQ      = 1'b1;
            pickFirst = 1'b1;
         end
         // R06: reserved codes flagged
         default: begin
            chanReserved = 1'b1;
         end
      endcase
   end

endmodule

// ===== verilog/rsc_sigpro_config_regs.v
/*
 * rsc_sigpro_config_regs.v: card-mode and reader-mode receive signal
 * processing configuration registers behind an Avalon-MM slave.
 * Assumes: one clock clk_sys, synchronous active-high srst, mode detector
 * logic on the same clock.
 */
// What this block does
// R01: mode detector writes detected framing itself
// R02: framing 00 type A, 01 sync F0
// R03: tap code maps to filter taps
// R04: edge threshold feeds edge decision stage
// R05: bit threshold feeds bit decision stage
// R06: channel code selects I, Q or both
// R07: 100 strongest channel, 101 first channel
// R08: software writes reserved bits as zero
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_sigpro_config_regs (
   // clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // avalon-mm slave (word addresses)
   input  wire [7:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   input  wire [3:0]  avsByteEnable,
   output reg  [31:0] avsReadData,
   output wire        avsWaitRequest,
   // mode detector
   input  wire        autoModeEnable,
   input  wire        modeDetected,
   input  wire [1:0]  detectedFraming,
   // card-mode demodulator configuration
   output reg  [1:0]  rxFraming,
   output reg         framingTypeA,
   output reg         framingNfcSync,
   output reg  [7:0]  syncByte,
   output reg  [5:0]  edgeFilterTaps,
   output reg  [12:0] edgeDecisionThreshold,
   output reg  [12:0] bitDecisionThreshold,
   // reader-mode phase channel control
   output reg  [2:0]  phaseChannelSelect,
   output reg         useChannelI,
   output reg         useChannelQ,
   output reg         pickStrongest,
   output reg         pickFirst,
   output reg         channelCodeReserved
);

   // ****************************************************************
   // storage
   // ****************************************************************
   reg  [31:0] cmConfig;
   reg  [31:0] rmConfig;
   reg         ackPending;
   wire [31:0] byteMask;
   wire        hitCm;
   wire        hitRm;
   wire        busReq;
   wire        wrCm;
   wire        wrRm;
   wire        detWrite;
   wire        decI;
   wire        decQ;
   wire        decStrong;
   wire        decFirst;
   wire        decRes;
   reg  [5:0]  next_taps;
   reg  [31:0] next_cm;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gMask
         assign byteMask[gi*8 +: 8] = {8{avsByteEnable[gi]}};
      end
   endgenerate

   assign hitCm    = (avsAddress == `RSC_IDX_CM_CONFIG);
   assign hitRm    = (avsAddress == `RSC_IDX_RM_CONFIG);
   assign busReq   = avsRead | avsWrite;
   // one wait cycle, then the access completes
   assign avsWaitRequest = busReq & ~ackPending;
   assign wrCm     = avsWrite & ackPending & hitCm;
   assign wrRm     = avsWrite & ackPending & hitRm;
   assign detWrite = autoModeEnable & modeDetected;

   // ****************************************************************
   // bus handshake and read data
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (srst) begin
         ackPending  <= 1'b0;
         avsReadData <= `RSC_RDATA_UNMAPPED;
      end else begin
         ackPending <= busReq & ~ackPending;
         if (avsRead & ~ackPending) begin
            // reserved bits read as zero
            if (hitCm)
               avsReadData <= cmConfig & `RSC_CM_WMASK;
            else if (hitRm)
               avsReadData <= rmConfig & `RSC_RM_WMASK;
            else
               avsReadData <= `RSC_RDATA_UNMAPPED;
         end
      end
   end

   // ****************************************************************
   // register update
   // ****************************************************************
   always @* begin
      next_cm = cmConfig;
      if (wrCm) begin
         // R08: reserved bit kept at zero
         next_cm = (cmConfig & ~(byteMask & `RSC_CM_WMASK)) |
                   (avsWriteData & byteMask & `RSC_CM_WMASK);
      end
      // R01: detector overrides framing
      if (detWrite) begin
         next_cm[`RSC_CM_FRAMING_HI:`RSC_CM_FRAMING_LO] = detectedFraming;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         cmConfig <= `RSC_CM_RESET;
         rmConfig <= `RSC_RM_RESET;
      end else begin
         cmConfig <= next_cm;
         if (wrRm) begin
            // R08: reserved bits dropped
            rmConfig <= (rmConfig & ~(byteMask & `RSC_RM_WMASK)) |
                        (avsWriteData & byteMask & `RSC_RM_WMASK);
         end
      end
   end

   // ****************************************************************
   // card-mode and reader-mode field decode
   // ****************************************************************
   always @* begin
      // R03: tap count lookup
      case (cmConfig[`RSC_CM_TAPSEL_HI:`RSC_CM_TAPSEL_LO])
         3'h0:    next_taps = `RSC_TAPS_0;
         3'h1:    next_taps = `RSC_TAPS_1;
         3'h2:    next_taps = `RSC_TAPS_2;
         3'h3:    next_taps = `RSC_TAPS_3;
         3'h4:    next_taps = `RSC_TAPS_4;
         3'h5:    next_taps = `RSC_TAPS_5;
         3'h6:    next_taps = `RSC_TAPS_6;
         default: next_taps = `RSC_TAPS_7;
      endcase
   end

   rsc_channel_decode uChanDec (
      .chanSel       (rmConfig[`RSC_RM_CHSEL_HI:`RSC_RM_CHSEL_LO]),
      .useI          (decI),
      .useQ          (decQ),
      .pickStrongest (decStrong),
      .pickFirst     (decFirst),
      .chanReserved  (decRes)
   );

   // outputs registered, so they follow the register one cycle later
   always @(posedge clk_sys) begin
      if (srst) begin
         rxFraming             <= 2'h0;
         framingTypeA          <= 1'b0;
         framingNfcSync        <= 1'b0;
         syncByte              <= 8'h00;
         edgeFilterTaps        <= 6'h00;
         edgeDecisionThreshold <= 13'h0000;
         bitDecisionThreshold  <= 13'h0000;
         phaseChannelSelect    <= 3'h0;
         useChannelI           <= 1'b0;
         useChannelQ           <= 1'b0;
         pickStrongest         <= 1'b0;
         pickFirst             <= 1'b0;
         channelCodeReserved   <= 1'b0;
      end else begin
         rxFraming <= cmConfig[`RSC_CM_FRAMING_HI:`RSC_CM_FRAMING_LO];
         // R02: framing decode and sync byte
         framingTypeA   <= (cmConfig[`RSC_CM_FRAMING_HI:`RSC_CM_FRAMING_LO]
                            == `RSC_FRAME_14443A);
         framingNfcSync <= (cmConfig[`RSC_CM_FRAMING_HI:`RSC_CM_FRAMING_LO]
                            == `RSC_FRAME_18092);
         syncByte <= (cmConfig[`RSC_CM_FRAMING_HI:`RSC_CM_FRAMING_LO]
                      == `RSC_FRAME_18092) ? `RSC_SYNC_BYTE_18092 : 8'h00;
         // R03: taps to edge filter
         edgeFilterTaps <= next_taps;
         // R04: edge decision threshold
         edgeDecisionThreshold <=
            cmConfig[`RSC_CM_EDGE_TH_HI:`RSC_CM_EDGE_TH_LO];
         // R05: bit decision threshold
         bitDecisionThreshold <=
            cmConfig[`RSC_CM_BIT_TH_HI:`RSC_CM_BIT_TH_LO];
         // R06: channel usage
         phaseChannelSelect <= rmConfig[`RSC_RM_CHSEL_HI:`RSC_RM_CHSEL_LO];
         useChannelI         <= decI;
         useChannelQ         <= decQ;
         channelCodeReserved <= decRes;
         // R07: strategy flags
         pickStrongest <= decStrong;
         pickFirst     <= decFirst;
      end
   end

endmodule

// ===== verification/rsc_checker.sv
/* rsc_checker: port assertions for the config bank.
   assumes: bound into rsc_sigpro_config_regs, one clock. */
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_checker (
   // clock and reset
   input wire        clk_sys,
   input wire        srst,
   // bus
   input wire [7:0]  avsAddress,
   input wire        avsRead,
   input wire        avsWrite,
   input wire [31:0] avsWriteData,
   input wire [3:0]  avsByteEnable,
   input wire [31:0] avsReadData,
   input wire        avsWaitRequest,
   // detector
   input wire        autoModeEnable,
   input wire        modeDetected,
   input wire [1:0]  detectedFraming,
   // outputs
   input wire [1:0]  rxFraming,
   input wire        framingTypeA,
   input wire [7:0]  syncByte,
   input wire [5:0]  edgeFilterTaps,
   input wire [12:0] edgeDecisionThreshold,
   input wire [12:0] bitDecisionThreshold,
   input wire [2:0]  phaseChannelSelect,
   input wire        useChannelI,
   input wire        pickStrongest,
   input wire        pickFirst
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   localparam logic [5:0] TAPT [8] = '{6'h04, 6'h06, 6'h08, 6'h08,
                                       6'h10, 6'h12, 6'h18, 6'h20};
   wire req  = avsRead || avsWrite;
   wire done = avsWrite && !avsWaitRequest && avsByteEnable == 4'hF;
   // detector wins on framing, so those cycles are left out
   wire cmW  = done && avsAddress == `RSC_IDX_CM_CONFIG
               && !(autoModeEnable && modeDetected);
   wire rmW  = done && avsAddress == `RSC_IDX_RM_CONFIG;
   property p_first; $rose(req) |-> avsWaitRequest; endproperty
   a_first: assert property (p_first) else $error("no wait cycle");
   property p_wait; req && avsWaitRequest |=> !avsWaitRequest; endproperty
   a_wait: assert property (p_wait) else $error("answer late");
   property p_det;
      autoModeEnable && modeDetected |->
         ##2 rxFraming == $past(detectedFraming, 2);
   endproperty
   a_det: assert property (p_det) else $error("detector lost");
   property p_frm;
      !$past(srst) |-> syncByte == (rxFraming == 2'h1 ? 8'hF0 : 8'h00)
         && framingTypeA == (rxFraming == 2'h0);
   endproperty
   a_frm: assert property (p_frm) else $error("framing decode");
   property p_tap;
      cmW |-> ##2 edgeFilterTaps == TAPT[$past(avsWriteData[28:26], 2)];
   endproperty
   a_tap: assert property (p_tap) else $error("tap count");
   property p_edg;
      cmW |-> ##2 edgeDecisionThreshold == $past(avsWriteData[25:13], 2);
   endproperty
   a_edg: assert property (p_edg) else $error("edge threshold");
   property p_bit;
      cmW |-> ##2 bitDecisionThreshold == $past(avsWriteData[12:0], 2);
   endproperty
   a_bit: assert property (p_bit) else $error("bit threshold");
   property p_chs;
      rmW |-> ##2 phaseChannelSelect == $past(avsWriteData[23:21], 2);
   endproperty
   a_chs: assert property (p_chs) else $error("channel code");
   property p_dec; !$past(srst) |-> useChannelI == !phaseChannelSelect[1];
   endproperty
   a_dec: assert property (p_dec) else $error("channel I use");
   property p_pick;
      !$past(srst) |-> pickStrongest == (phaseChannelSelect == 3'h4)
         && pickFirst == (phaseChannelSelect == 3'h5);
   endproperty
   a_pick: assert property (p_pick) else $error("pick mode");
   property p_rsv;
      avsRead && !avsWaitRequest && avsAddress == `RSC_IDX_RM_CONFIG
         |-> avsReadData[31:24] == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   c_cm: cover property (cmW);
   c_rm: cover property (rmW);
   c_det: cover property (autoModeEnable && modeDetected);
endmodule
bind rsc_sigpro_config_regs rsc_checker u_chk (.clk_sys, .srst,
   .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
   .avsReadData, .avsWaitRequest, .autoModeEnable, .modeDetected,
   .detectedFraming, .rxFraming, .framingTypeA, .syncByte,
   .edgeFilterTaps, .edgeDecisionThreshold, .bitDecisionThreshold,
   .phaseChannelSelect, .useChannelI, .pickStrongest, .pickFirst);

// ===== verification/rsc_sigpro_config_regs_tb.sv
/* rsc_sigpro_config_regs_tb: self-checking bench for the config bank.
   assumes: checker bound in its own file. */
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_sigpro_config_regs_tb;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  avsAddress = 8'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [3:0]  avsByteEnable = 4'h0;
   logic        autoModeEnable = 1'b0;
   logic        modeDetected = 1'b0;
   logic [1:0]  detectedFraming = 2'h0;
   wire  [31:0] avsReadData;
   wire         avsWaitRequest;
   wire         framingNfcSync;
   wire  [7:0]  syncByte;
   wire  [5:0]  edgeFilterTaps;
   wire  [12:0] edgeDecisionThreshold;
   wire  [12:0] bitDecisionThreshold;
   wire  [2:0]  phaseChannelSelect;
   wire  [4:0]  flags;
   logic [31:0] expQ [$];
   logic [31:0] d;
   logic [31:0] cm;
   int          n_fail = 0;
   int          n_compared = 0;
   localparam logic [5:0] TAPT [8] = '{6'h04, 6'h06, 6'h08, 6'h08,
                                       6'h10, 6'h12, 6'h18, 6'h20};
   // I, Q, strongest, first, reserved per code
   localparam logic [4:0] CHT [8] = '{5'h18, 5'h10, 5'h08, 5'h01,
                                      5'h1C, 5'h1A, 5'h01, 5'h01};
   always #20 clk_sys = ~clk_sys;
   rsc_sigpro_config_regs dut (.clk_sys, .srst, .avsAddress, .avsRead,
      .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData,
      .avsWaitRequest, .autoModeEnable, .modeDetected, .detectedFraming,
      .rxFraming(), .framingTypeA(), .framingNfcSync, .syncByte,
      .edgeFilterTaps, .edgeDecisionThreshold, .bitDecisionThreshold,
      .phaseChannelSelect, .useChannelI(flags[4]), .useChannelQ(flags[3]),
      .pickStrongest(flags[2]), .pickFirst(flags[1]),
      .channelCodeReserved(flags[0]));
   task automatic cmp(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************
   // bus master, held until waitrequest is seen low
   // ****************
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] v, input logic [3:0] be);
      int k;
      avsWrite <= w;
      avsRead <= !w;
      avsAddress <= a;
      avsWriteData <= v;
      avsByteEnable <= be;
      k = 0;
      // waitrequest is looked at on the rising edge itself, before the
      // design's own updates for that edge land
      do begin
         @(posedge clk_sys);
         k++;
      end while (avsWaitRequest !== 1'b0 && k < 20);
      if (avsWaitRequest !== 1'b0) begin
         n_fail++;
         $display("unexpected waitRequest exp 0 got %b", avsWaitRequest);
         stop_test();
      end
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic pulse(input logic en);
      autoModeEnable <= en;
      modeDetected <= 1'b1;
      @(posedge clk_sys);
      autoModeEnable <= 1'b0;
      modeDetected <= 1'b0;
      @(posedge clk_sys);
   endtask
   // read data taken at the completing rising edge only
   always @(posedge clk_sys)
      if (avsRead && avsWaitRequest === 1'b0 && expQ.size() > 0)
         cmp("readData", expQ.pop_front(), avsReadData);
   initial begin
      void'($urandom(16));
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rd(`RSC_IDX_CM_CONFIG, 32'h0);
      rd(`RSC_IDX_RM_CONFIG, 32'h0);
      // lane enable honoured, bit 31 never stored
      bus(1'b1, `RSC_IDX_CM_CONFIG, 32'hFFFFFFFF, 4'h8);
      rd(`RSC_IDX_CM_CONFIG, 32'h7F000000);
      $display("test reset and lanes done");
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         d[31:26] = {1'b1, 1'b0, i[0], i[2:0]};
         bus(1'b1, `RSC_IDX_CM_CONFIG, d, 4'hF);
         @(negedge clk_sys);
         cmp("taps", 32'(TAPT[i]), 32'(edgeFilterTaps));
         cmp("edgeTh", 32'(d[25:13]), 32'(edgeDecisionThreshold));
         cmp("bitTh", 32'(d[12:0]), 32'(bitDecisionThreshold));
         cmp("sync", {i[0], 23'h0, i[0] ? 8'hF0 : 8'h00},
             {framingNfcSync, 23'h0, syncByte});
         @(posedge clk_sys);
         cm = d & `RSC_CM_WMASK;
         rd(`RSC_IDX_CM_CONFIG, cm);
      end
      $display("test card mode done");
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         d[23:21] = i[2:0];
         bus(1'b1, `RSC_IDX_RM_CONFIG, d, 4'hF);
         @(negedge clk_sys);
         cmp("chan", {24'h0, CHT[i], i[2:0]},
             {24'h0, flags, phaseChannelSelect});
         @(posedge clk_sys);
         rd(`RSC_IDX_RM_CONFIG, d & `RSC_RM_WMASK);
      end
      $display("test reader mode done");
      bus(1'b1, 8'h1D, 32'hFFFFFFFF, 4'hF);
      rd(8'h1D, 32'h0);
      rd(`RSC_IDX_CM_CONFIG, cm);
      pulse(1'b0);
      rd(`RSC_IDX_CM_CONFIG, cm);
      pulse(1'b1);
      rd(`RSC_IDX_CM_CONFIG, cm & 32'h9FFFFFFF);
      $display("test unmapped and detector done");
      stop_test();
   end
endmodule
